// ---- hw/asrc_cfg.svh ----
/*
 timing and width constants for the async sram host controller.
 assumes a 20 mhz core clock; times are in ns, counts are derived.
*/
`ifndef ASRC_CFG_SVH
`define ASRC_CFG_SVH
// -----------------------------------------------------------
// clock
// -----------------------------------------------------------
`define ASRC_CLK_PERIOD_NS   50
// -----------------------------------------------------------
// slow grade timing (ns), the safe default
// -----------------------------------------------------------
`define ASRC_READ_CYCLE_NS   45
`define ASRC_ADDR_SETUP_NS   25
`define ASRC_DATA_SETUP_NS   20
`define ASRC_WE_PULSE_NS     25
`define ASRC_CS_WRITE_NS     35
`define ASRC_RETAIN_SETUP_NS 0
// least times round up, never below one cycle
`define ASRC_CYC(ns) (((ns) + `ASRC_CLK_PERIOD_NS - 1) / `ASRC_CLK_PERIOD_NS < 1 ? 1 : \
   ((ns) + `ASRC_CLK_PERIOD_NS - 1) / `ASRC_CLK_PERIOD_NS)
// -----------------------------------------------------------
// widths
// -----------------------------------------------------------
`define ASRC_ADDR_W 15
`define ASRC_DATA_W 8
// synchroniser depth on the data read-back path
`define ASRC_SYNC_STAGES 3
// phase timer width, ample for the longest phase at this clock
`define ASRC_CNT_W 4
`endif

// ---- hw/asrc_pkg.sv ----
/*
 types for the async sram host controller.
 assumes asrc_cfg.svh is compiled alongside.
*/
package asrc_pkg;
   // controller states
   typedef enum logic [2:0]
   {
      IDLE_ST  = 3'b000,
      READ_ST  = 3'b001,
      WRITE_ST = 3'b010,
      END_ST   = 3'b011,
      SLEEP_ST = 3'b100
   } asrc_state_type;
   // sram control pins, all active low
   typedef struct packed
   {
      logic chipSelN;
      logic outEnN;
      logic writeEnN;
   } asrc_ctrl_type;
endpackage

// ---- hw/asrc_host.sv ----
/*
 host side controller driving a 32k x 8 asynchronous sram over its pins.
 assumes the sram sits on the same board; data_pins read back through a
 three stage synchroniser; user requests are same-clock logic.
*/
`timescale 1ns/100ps
`include "asrc_cfg.svh"

// Function
// - write starts valid, ends at first rise
// - data held around terminating edge
// - write enable high through reads
// - address valid by select falling edge
// - address set up before write end
// - address may change at write end
// - data set up before write end
// - data may drop at write end
// - deselect before retention, zero setup
module asrc_host
#(
   parameter int ADDR_W = `ASRC_ADDR_W,
   parameter int DATA_W = `ASRC_DATA_W
)
(
   input  wire logic                  core_clk,
   input  wire logic                  reset,
   input  wire logic                  reqValid,
   input  wire logic                  reqWrite,
   input  wire logic [ADDR_W-1:0]     reqAddr,
   input  wire logic [DATA_W-1:0]     reqData,
   output logic                       reqReady,
   output logic                       rdValid,
   output logic [DATA_W-1:0]          rdData,
   input  wire logic                  retainReq,
   output logic                       retainAck,
   output logic [ADDR_W-1:0]          word_address,
   output asrc_pkg::asrc_ctrl_type    sramCtrl,
   input  wire logic [DATA_W-1:0]     data_pins_in,
   output logic [DATA_W-1:0]          data_pins_out,
   output logic                       data_pins_oe
);
   // -----------------------------------------------------------
   // derived cycle counts
   // -----------------------------------------------------------
   // read waits for access time plus the three stage synchroniser
   localparam int READ_CYC = `ASRC_CYC(`ASRC_READ_CYCLE_NS) + `ASRC_SYNC_STAGES;
   localparam int WE_CYC   = `ASRC_CYC(`ASRC_WE_PULSE_NS);
   localparam int ADS_CYC  = `ASRC_CYC(`ASRC_ADDR_SETUP_NS);
   localparam int DS_CYC   = `ASRC_CYC(`ASRC_DATA_SETUP_NS);
   localparam int CSW_CYC  = `ASRC_CYC(`ASRC_CS_WRITE_NS);
   // write low time covers every setup figure
   localparam int W1 = WE_CYC > ADS_CYC ? WE_CYC : ADS_CYC;
   localparam int W2 = DS_CYC > CSW_CYC ? DS_CYC : CSW_CYC;
   localparam int WR_CYC = W1 > W2 ? W1 : W2;
   // timer width; a longer phase at a faster clock needs more bits
   localparam int CNT_W  = `ASRC_CNT_W;

   // -----------------------------------------------------------
   // state and registers
   // -----------------------------------------------------------
   asrc_pkg::asrc_state_type state_r;        // current phase
   asrc_pkg::asrc_state_type state_nxt;      // next phase
   logic [CNT_W-1:0]         cnt_r;          // phase timer
   logic [CNT_W-1:0]         cnt_nxt;        // timer next
   logic [ADDR_W-1:0]        addr_r;         // latched address
   logic [DATA_W-1:0]        wdata_r;        // latched write data
   logic [DATA_W-1:0]        sync1_r;        // sync stage one
   logic [DATA_W-1:0]        sync2_r;        // sync stage two
   logic [DATA_W-1:0]        sync3_r;        // sync stage three
   logic                     cntDone;        // timer expired
   logic                     idleTake;       // request accepted
   logic                     readDone;       // read sample point
   logic                     readNxt;        // read phase next cycle
   logic                     writeNxt;       // write phase next cycle
   logic                     selNxt;         // select wanted next cycle
   logic [ADDR_W-1:0]        addrNxt;        // address for next cycle

   assign cntDone  = (cnt_r == CNT_W'(0));
   assign idleTake = (state_r == asrc_pkg::IDLE_ST) && reqValid && !retainReq;
   assign readDone = (state_r == asrc_pkg::READ_ST) && cntDone && (sync2_r == sync3_r);
   assign reqReady = (state_r == asrc_pkg::IDLE_ST) && !retainReq;
   assign retainAck = (state_r == asrc_pkg::SLEEP_ST);

   // -----------------------------------------------------------
   // next state
   // -----------------------------------------------------------
   // timer counts down; read and write phases each load their own length
   always_comb
   begin
      state_nxt = state_r;
      cnt_nxt   = cntDone ? cnt_r : cnt_r - CNT_W'(1);
      unique case (state_r)
         asrc_pkg::IDLE_ST:
         begin
            // retention request wins over new accesses
            // deselect at retention entry
            if (retainReq)
               state_nxt = asrc_pkg::SLEEP_ST;
            else if (reqValid)
            begin
               state_nxt = reqWrite ? asrc_pkg::WRITE_ST : asrc_pkg::READ_ST;
               cnt_nxt   = reqWrite ? CNT_W'(WR_CYC - 1) : CNT_W'(READ_CYC - 1);
            end
         end
         asrc_pkg::READ_ST:
         begin
            // only finish once synchroniser stages agree
            if (readDone)
               state_nxt = asrc_pkg::END_ST;
         end
         asrc_pkg::WRITE_ST:
         begin
            if (cntDone)
               state_nxt = asrc_pkg::END_ST;
         end
         asrc_pkg::END_ST:
            state_nxt = asrc_pkg::IDLE_ST;
         asrc_pkg::SLEEP_ST:
         begin
            // recovery after retention handled by end phase gap
            if (!retainReq)
               state_nxt = asrc_pkg::END_ST;
         end
         default:
            state_nxt = asrc_pkg::IDLE_ST;
      endcase
   end

   // -----------------------------------------------------------
   // sequential
   // -----------------------------------------------------------
   always_ff @(posedge core_clk)
   begin
      if (reset)
      begin
         state_r <= asrc_pkg::IDLE_ST;
         cnt_r   <= '0;
         addr_r  <= '0;
         wdata_r <= '0;
      end
      else
      begin
         state_r <= state_nxt;
         cnt_r   <= cnt_nxt;
         if (idleTake)
         begin
            addr_r  <= reqAddr;
            wdata_r <= reqData;
         end
      end
   end

   // pins cross domains: three flops, second and third must agree
   // a bit caught mid-change may settle either way in stage one;
   // waiting for agreement keeps such a bit out of the result
   always_ff @(posedge core_clk)
   begin
      sync1_r <= data_pins_in;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
   end

   // read result register
   // data holds until the next read so a slow consumer still sees it
   always_ff @(posedge core_clk)
   begin
      if (reset)
      begin
         rdValid <= 1'b0;
         rdData  <= '0;
      end
      else
      begin
         rdValid <= readDone;
         if (readDone)
            rdData <= sync3_r;
      end
   end

   // -----------------------------------------------------------
   // pin drive, registered
   // -----------------------------------------------------------
   // phase decode of the next state, shared by the pin drivers
   assign readNxt  = (state_nxt == asrc_pkg::READ_ST);
   assign writeNxt = (state_nxt == asrc_pkg::WRITE_ST);
   assign selNxt   = readNxt || writeNxt;
   // address moves only when a new access is taken, so it is
   // set on the same edge that select falls and steady while selected
   assign addrNxt  = (state_nxt == asrc_pkg::IDLE_ST) ? word_address : (idleTake ? reqAddr : addr_r);

   // select and write enable fall together so every control is valid
   // at write start; they rise together too, and either edge ends the
   // write, so data setup is counted to that shared edge
   always_ff @(posedge core_clk)
   begin
      if (reset)
      begin
         sramCtrl      <= '{chipSelN: 1'b1, outEnN: 1'b1, writeEnN: 1'b1};
         word_address  <= '0;
         data_pins_out <= '0;
         data_pins_oe  <= 1'b0;
      end
      else
      begin
         word_address  <= addrNxt;
         data_pins_out <= idleTake ? reqData : wdata_r;
         // select and write overlap only in write phase
         sramCtrl.chipSelN <= !selNxt;
         // write enable high outside write phase
         sramCtrl.writeEnN <= !writeNxt;
         // output enable held high while writing
         sramCtrl.outEnN   <= !readNxt;
         // data held through the terminating edge
         data_pins_oe      <= writeNxt || (state_r == asrc_pkg::WRITE_ST);
      end
   end
endmodule

// ---- sim/asrc_host_asserts.sv ----
/* pin rules of the sram host controller.
 assumes it is bound into asrc_host; one clock domain. */
`timescale 1ns/100ps
module asrc_host_asserts
#(
   parameter int ADDR_W = 15,
   parameter int DATA_W = 8
)
(
   input wire logic                    core_clk,
   input wire logic                    reset,
   input wire logic                    reqValid,
   input wire logic                    reqWrite,
   input wire logic                    reqReady,
   input wire logic                    rdValid,
   input wire logic                    retainReq,
   input wire logic                    retainAck,
   input wire logic [ADDR_W-1:0]       word_address,
   input wire asrc_pkg::asrc_ctrl_type sramCtrl,
   input wire logic [DATA_W-1:0]       data_pins_out,
   input wire logic                    data_pins_oe
);
   logic takeW;
   logic takeR;
   // accepted write and read requests
   assign takeW = reqValid && reqReady && reqWrite;
   assign takeR = reqValid && reqReady && !reqWrite;
   default clocking @(posedge core_clk); endclocking
   default disable iff (reset);
   read_no_write_a: assert property (!sramCtrl.chipSelN && !sramCtrl.outEnN |-> sramCtrl.writeEnN)
      else $error("write enable low in a read");
   write_drive_a: assert property (!sramCtrl.writeEnN |-> !sramCtrl.chipSelN && data_pins_oe)
      else $error("write without select or data");
   no_contend_a: assert property (data_pins_oe |-> sramCtrl.outEnN)
      else $error("host drives while sram may drive");
   data_hold_a: assert property ($rose(sramCtrl.writeEnN) |-> data_pins_oe && $stable(data_pins_out))
      else $error("data moved at write end");
   addr_stable_a: assert property (!sramCtrl.chipSelN && !$past(sramCtrl.chipSelN) |-> $stable(word_address))
      else $error("address moved while selected");
   write_end_a: assert property (takeW |=> !sramCtrl.writeEnN ##1 sramCtrl.writeEnN)
      else $error("write pulse not one cycle");
   retain_desel_a: assert property (retainAck |-> sramCtrl.chipSelN)
      else $error("selected in retention");
   retain_refuse_a: assert property (retainReq |-> !reqReady)
      else $error("request taken during retention");
   // timer of four plus agreement: the answer shows five edges after the take
   read_answer_a: assert property (takeR |-> ##[5:8] rdValid)
      else $error("read answer late");
   data_release_a: assert property ($rose(sramCtrl.writeEnN) |=> !data_pins_oe)
      else $error("data still driven after write end");
   cover property (takeW);
   cover property (rdValid);
   cover property (retainAck);
endmodule
bind asrc_host asrc_host_asserts #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) chk (.core_clk(core_clk), .reset(reset),
   .reqValid(reqValid), .reqWrite(reqWrite), .reqReady(reqReady), .rdValid(rdValid), .retainReq(retainReq),
   .retainAck(retainAck), .word_address(word_address), .sramCtrl(sramCtrl), .data_pins_out(data_pins_out),
   .data_pins_oe(data_pins_oe));

// ---- sim/asrc_sram_model.sv ----
/* behavioural 32k x 8 static memory at the controller pins.
 assumes no pull on the data lines, so a released bus shows inverted data. */
`timescale 1ns/100ps
module asrc_sram_model
#(
   parameter int ACC_NS = 45
)
(
   input wire logic [14:0]             word_address,
   input wire asrc_pkg::asrc_ctrl_type sramCtrl,
   input wire logic [7:0]              hostData,
   output logic [7:0]                  data_pins
);
   logic [7:0] mem [0:32767]; // storage
   logic [7:0] lastQ = 8'h00; // last word driven
   logic [7:0] accQ;          // word after access time
   logic       driveEn;
   assign driveEn = !sramCtrl.chipSelN && !sramCtrl.outEnN && sramCtrl.writeEnN;
   always @*
      if (!sramCtrl.chipSelN && !sramCtrl.writeEnN)
         mem[word_address] = hostData;
   always @*
      if (driveEn)
         lastQ = mem[word_address];
   assign #(ACC_NS) accQ = lastQ;
   assign data_pins = driveEn ? accQ : ~lastQ;
endmodule

// ---- sim/async_sram_read_write_timing_tb.sv ----
/* bench for the sram host controller with a behavioural sram.
 assumes 20 mhz core clock and synchronous active high reset. */
`timescale 1ns/100ps
module async_sram_read_write_timing_tb;
   logic core_clk, reset, reqValid, reqWrite, reqReady, rdValid, retainReq, retainAck, oe;
   logic [14:0] reqAddr, addr;
   logic [7:0] reqData, rdData, hostOut, memOut, bus;
   asrc_pkg::asrc_ctrl_type ctrl;
   int failures = 0;
   int total_checks = 0;
   // host drive wins on the shared data lines
   assign bus = oe ? hostOut : memOut;
   asrc_host dut (.core_clk(core_clk), .reset(reset), .reqValid(reqValid), .reqWrite(reqWrite),
      .reqAddr(reqAddr), .reqData(reqData), .reqReady(reqReady), .rdValid(rdValid), .rdData(rdData),
      .retainReq(retainReq), .retainAck(retainAck), .word_address(addr), .sramCtrl(ctrl),
      .data_pins_in(bus), .data_pins_out(hostOut), .data_pins_oe(oe));
   asrc_sram_model sram (.word_address(addr), .sramCtrl(ctrl), .hostData(bus), .data_pins(memOut));
   initial
   begin
      core_clk = 1'b0;
      forever #25 core_clk = ~core_clk;
   end
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         failures++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   // one access; a read waits for its answer
   task automatic access(input logic w, input logic [14:0] a, input logic [7:0] d);
      int n;
      @(posedge core_clk);
      #5;
      reqValid = 1'b1;
      reqWrite = w;
      reqAddr = a;
      reqData = d;
      n = 0;
      while (reqReady !== 1'b1 && n < 50)
      begin
         @(posedge core_clk);
         #5;
         n++;
      end
      // a request never taken counts as a mismatch
      if (n >= 50)
      begin
         failures++;
         $display("unexpected at %0t: request never taken", $time);
      end
      @(posedge core_clk);
      #5;
      reqValid = 1'b0;
      n = 0;
      while (!w && rdValid !== 1'b1 && n < 40)
      begin
         @(posedge core_clk);
         #5;
         n++;
      end
      // a read answer that never comes counts as a mismatch
      if (n >= 40)
      begin
         failures++;
         $display("unexpected at %0t: read answer missing", $time);
      end
   endtask
   task automatic t_write_read();
      logic [14:0] a [4] = '{15'h0000, 15'h7fff, 15'h2aaa, 15'h5555};
      logic [7:0] d [4] = '{8'ha5, 8'h5a, 8'hff, 8'h00};
      for (int i = 0; i < 4; i++)
         access(1'b1, a[i], d[i]);
      for (int i = 3; i >= 0; i--)
      begin
         access(1'b0, a[i], 8'h00);
         chk(rdData, d[i]);
      end
   endtask
   task automatic t_retain();
      @(posedge core_clk);
      #5;
      retainReq = 1'b1;
      reqValid = 1'b1;
      reqWrite = 1'b1;
      reqAddr = 15'h0000;
      reqData = 8'h77;
      repeat (4) @(posedge core_clk);
      #5;
      chk({6'h00, reqReady, retainAck}, 8'h01);
      chk({7'h00, ctrl.chipSelN}, 8'h01);
      reqValid = 1'b0;
      retainReq = 1'b0;
      access(1'b0, 15'h0000, 8'h00);
      chk(rdData, 8'ha5);
   endtask
   task automatic close_out();
      if (failures == 0 && total_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   // watchdog against a hung handshake
   initial
   begin
      #200000;
      failures++;
      $display("unexpected at %0t: run hung", $time);
      close_out();
   end
   initial
   begin
      reset = 1'b1;
      reqValid = 1'b0;
      reqWrite = 1'b0;
      reqAddr = 15'h0000;
      reqData = 8'h00;
      retainReq = 1'b0;
      repeat (10) @(posedge core_clk);
      #5;
      reset = 1'b0;
      t_write_read();
      t_retain();
      close_out();
   end
endmodule
